// >>> adc_register_host_port_tb_top.sv
/* self-checking bench for arhp_top against an integer model.
   needs arhp_pkg, arhp_host and arhp_checker. */
module adc_register_host_port_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk_sys, nrst, core_range, select_n, write_n, drive_n, range_exceeded;
  logic [1:0] addr;
  logic [13:0] core_code, data_in, data_out, data_oe, rd_v;
  arhp_pkg::arhp_analog_type analog_ctl;
  int err_count, total_checks, seed;
  logic [13:0] mdl[4];
  logic [13:0] mask[4] = '{14'h0, 14'h7, 14'hFF, 14'h3F80};
  int src[8] = '{0, 5, 13, 9, 0, 10, 7, 6};
  arhp_top arhp_top_i (.*);
  arhp_host arhp_host_i (.*);
  task automatic chk(input string n, input logic [13:0] e, input logic [13:0] v);
    total_checks++;
    if (v !== e)
    begin
      err_count++;
      $display("BAD %s expected %h seen %h", n, e, v);
    end
  endtask
  task automatic finish_test;
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic put(input int a, input logic [13:0] d, input logic sn);
    arhp_host_i.wr(a[1:0], d, sn);
    if (!sn && a != 0)
      mdl[a] = d & mask[a];
  endtask
  task automatic do_reset;
    nrst = 1'b0;
    repeat (4) @(negedge clk_sys);
    nrst = 1'b1;
    mdl = '{4{14'h0}};
    for (int a = 1; a < 4; a++)
    begin
      arhp_host_i.rd(a[1:0], rd_v);
      chk("reset value", 14'h0, rd_v);
    end
    $display("reset test done");
  endtask
  // saturation is what keeps a trimmed extreme code from wrapping
  function automatic logic [13:0] conv(input int c);
    int v = c;
    if (!mdl[3][7])
      v = v + $signed(mdl[2][7:0]);
    v = v < 0 ? 0 : (v > 16383 ? 16383 : v);
    return mdl[3][11] ? v[13:0] ^ 14'h2000 : v[13:0];
  endfunction
  initial
  begin
    clk_sys = 1'b0;
    forever #2 clk_sys = ~clk_sys;
  end
  initial
  begin
    #100000;
    err_count++;
    finish_test();
  end
  initial
  begin
    nrst = 1'b0;
    seed = 32'h775E;
    core_code = 14'h0;
    core_range = 1'b0;
    do_reset();
    for (int i = 0; i < 12; i++)
    begin
      put(i % 4, 14'($random(seed)), i > 8);
      arhp_host_i.rd(2'(i % 4), rd_v);
      if (i % 4 != 0)
        chk("readback", mdl[i % 4], rd_v);
    end
    $display("register test done");
    for (int c = 0; c < 8; c++)
    begin
      put(3, 14'(c << 8 | c << 11), 1'b0);
      repeat (2) @(negedge clk_sys);
      chk("routing", 14'(src[c]), 14'(analog_ctl[3:0]));
      chk("power ref", 14'(c >> 1), 14'(analog_ctl[8:7]));
      chk("gain", mdl[1], 14'(analog_ctl.gain_code));
    end
    $display("steering test done");
    for (int i = 0; i < 16; i++)
    begin
      put(2, 14'($random(seed)), 1'b0);
      put(3, 14'((i & 1) << 7 | (i & 2) << 10), 1'b0);
      core_code = i < 4 ? 14'h0 : (i < 8 ? 14'h3FFF : 14'($random(seed)));
      repeat (12)
      begin
        @(negedge clk_sys);
        core_range = 1'($random(seed));
      end
      arhp_host_i.rd(2'h0, rd_v);
      chk("result", conv(core_code), rd_v);
    end
    put(3, 14'h0880, 1'b0);
    core_code = 14'h1FFB;
    repeat (12) @(negedge clk_sys);
    arhp_host_i.rd(2'h0, rd_v);
    put(2, rd_v, 1'b0);
    put(3, 14'h0800, 1'b0);
    repeat (12) @(negedge clk_sys);
    arhp_host_i.rd(2'h0, rd_v);
    chk("calibrated", conv(core_code), rd_v);
    $display("conversion test done");
    do_reset();
    finish_test();
  end
endmodule

// >>> arhp_checker.sv
/* port checker for arhp_top.
   bound to every arhp_top instance; one clock domain. */
module arhp_checker (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // core and host pins
  input wire logic core_range,
  input arhp_pkg::arhp_analog_type analog_ctl,
  input wire logic range_exceeded,
  input wire logic [1:0] addr,
  input wire logic select_n,
  input wire logic write_n,
  input wire logic drive_n,
  input wire logic [13:0] data_in,
  input wire logic [13:0] data_out,
  input wire logic [13:0] data_oe
);
  int run;
  logic wn_d;
  wire take = !wn_d && write_n && !select_n;
  // sleep may blank the pipe, so the range check restarts after it
  always_ff @(posedge clk_sys or negedge nrst)
    if (!nrst)
    begin
      run <= 0;
      wn_d <= 1'b1;
    end
    else
    begin
      wn_d <= write_n;
      run <= analog_ctl.sleep_mode ? 0 : (run < 11 ? run + 1 : run);
    end
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  oe_follow_a:
    assert property (data_oe == {14{!drive_n}}) else $error("drive bad");
  range_align_a:
    assert property (run == 11 |-> range_exceeded == $past(core_range, 10))
    else $error("range flag misaligned");
  gain_pad_a:
    assert property ($past(addr) == 2'h1 |-> data_out[13:3] == 11'h0)
    else $error("gain upper bits set");
  offset_pad_a:
    assert property ($past(addr) == 2'h2 |-> data_out[13:8] == 6'h0)
    else $error("offset upper bits set");
  ctl_write_a:
    assert property (take && addr == 2'h3 |->
      ##2 data_out == $past(data_in, 2))
    else $error("control write lost");
  gain_write_a:
    assert property (take && addr == 2'h1 |->
      ##2 analog_ctl.gain_code == $past(data_in[2:0], 2))
    else $error("gain code wrong");
  analog_write_a:
    assert property (take && addr == 2'h3 |-> ##2
      {analog_ctl.sleep_mode, analog_ctl.ext_bandgap} == $past(data_in[13:12], 2))
    else $error("sleep or bandgap wrong");
  unsel_write_a:
    assert property (!wn_d && write_n && select_n && addr == 2'h3 &&
      $past(addr) == 2'h3 |=> $stable(data_out))
    else $error("unselected write taken");
  reset_clear_a:
    assert property ($rose(nrst) |-> data_out == 14'h0 &&
      analog_ctl == 9'h000 && !range_exceeded) else $error("reset not clear");
  cover property (take);
  cover property (run == 11 && range_exceeded);
  cover property (!drive_n && $past(addr) == 2'h0);
endmodule
bind arhp_top arhp_checker arhp_checker_i (.*);

// >>> arhp_host.sv
/* host processor model for the register port.
   changes pins only on falling clk_sys edges. */
module arhp_host (
  // clock
  input wire logic clk_sys,
  // bus pins
  output logic [1:0] addr,
  output logic select_n,
  output logic write_n,
  output logic drive_n,
  output logic [13:0] data_in,
  input wire logic [13:0] data_out,
  input wire logic [13:0] data_oe
);
  initial
  begin
    addr = 2'h0;
    select_n = 1'b1;
    write_n = 1'b1;
    drive_n = 1'b1;
    data_in = 14'h0;
  end
  task automatic wr(input logic [1:0] a, input logic [13:0] d, input logic sn);
    @(negedge clk_sys);
    addr = a;
    data_in = (a == 2'h3) ? {d[13:7], 7'h00} : d;
    select_n = sn;
    write_n = 1'b0;
    @(negedge clk_sys);
    write_n = 1'b1;
    @(negedge clk_sys);
    select_n = 1'b1;
    data_in = ~data_in;
  endtask
  task automatic rd(input logic [1:0] a, output logic [13:0] d);
    @(negedge clk_sys);
    addr = a;
    drive_n = 1'b0;
    @(negedge clk_sys);
    d = data_out & data_oe;
    drive_n = 1'b1;
  endtask
endmodule

// >>> arhp_map.svh
/*
  register offsets, field positions, reset values and timing counts for the
  converter register and host port block. definitions only.
*/
`ifndef ARHP_MAP_SVH
`define ARHP_MAP_SVH
// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define ARHP_ADDR_RESULT 2'h0
`define ARHP_ADDR_GAIN 2'h1
`define ARHP_ADDR_OFFSET 2'h2
`define ARHP_ADDR_CONTROL 2'h3
// ----------------------------------------------------------------
// control fields
// ----------------------------------------------------------------
`define ARHP_CTL_SLEEP 13
`define ARHP_CTL_EXT_BANDGAP 12
`define ARHP_CTL_TWOS_COMP 11
`define ARHP_CTL_CHECK_HI 10
`define ARHP_CTL_CHECK_LO 8
`define ARHP_CTL_TRIM_BYPASS 7
`define ARHP_GAIN_HI 2
`define ARHP_OFFSET_HI 7
// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define ARHP_RST_GAIN 3'h0
`define ARHP_RST_OFFSET 8'h00
`define ARHP_RST_CONTROL 14'h0000
// ----------------------------------------------------------------
// timing: latency of 9.5 sample clocks, rounded up to rising stages; the
// half cycle is taken back by the falling-edge stage after the pipe
// ----------------------------------------------------------------
`define ARHP_LATENCY_HALF_CYCLES 19
`define ARHP_PIPE_DEPTH ((`ARHP_LATENCY_HALF_CYCLES + 1) / 2)
`define ARHP_MID_CODE 14'h2000
`define ARHP_MAX_CODE 14'h3FFF
`endif

// >>> arhp_pkg.sv
/*
  types shared by the converter register and host port block.
  assumes arhp_map.svh is compiled alongside.
*/
package arhp_pkg;
  // ----------------------------------------------------------------
  // self-check input routing
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ARHP_CHK_NORMAL = 3'h0,
    ARHP_CHK_BOTH_NEG = 3'h1,
    ARHP_CHK_CM_NEG = 3'h2,
    ARHP_CHK_POS_NEG = 3'h3,
    ARHP_CHK_NORMAL_ALT = 3'h4,
    ARHP_CHK_BOTH_POS = 3'h5,
    ARHP_CHK_NEG_CM = 3'h6,
    ARHP_CHK_NEG_POS = 3'h7
  } arhp_check_type;

  // ----------------------------------------------------------------
  // analog front-end steering
  // ----------------------------------------------------------------
  typedef struct packed {
    logic sleep_mode;
    logic ext_bandgap;
    logic [2:0] gain_code;
    logic [1:0] pos_src;
    logic [1:0] neg_src;
  } arhp_analog_type;

  // sample carried through the pipeline
  typedef struct packed {
    logic [13:0] code;
    logic range_exceeded;
  } arhp_sample_type;
endpackage

// >>> arhp_top.sv
/*
  converter register and host port: four registers, read as 14-bit words, selected by two
  address lines, output formatting, offset trim, range flag pipeline and
  analog steering.
  assumes: core codes arrive as offset-binary once per rising clk_sys edge; host
  pins are synchronous to clk_sys; data pins resolved by the bench.
*/
`include "arhp_map.svh"
module arhp_top #(
  parameter int DEPTH = `ARHP_PIPE_DEPTH
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // converter core
  input wire logic [13:0] core_code,
  input wire logic core_range,
  output arhp_pkg::arhp_analog_type analog_ctl,
  output logic range_exceeded,
  // host bus
  input wire logic [1:0] addr,
  input wire logic select_n,
  input wire logic write_n,
  input wire logic drive_n,
  input wire logic [13:0] data_in,
  output logic [13:0] data_out,
  output logic [13:0] data_oe
);
  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [2:0] gain_setting;
  logic [7:0] offset_trim;
  logic [13:0] converter_control;
  logic [13:0] conversion_result;
  logic write_n_q;
  arhp_pkg::arhp_sample_type pipe [DEPTH];
  arhp_pkg::arhp_sample_type head;

  // ----------------------------------------------------------------
  // write decode
  // ----------------------------------------------------------------
  wire write_edge = write_n & ~write_n_q & ~select_n;
  wire wr_gain = write_edge & (addr == `ARHP_ADDR_GAIN);
  wire wr_offset = write_edge & (addr == `ARHP_ADDR_OFFSET);
  wire wr_control = write_edge & (addr == `ARHP_ADDR_CONTROL);

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      write_n_q <= 1'b1;
      gain_setting <= `ARHP_RST_GAIN;
      offset_trim <= `ARHP_RST_OFFSET;
      converter_control <= `ARHP_RST_CONTROL;
    end
    else
    begin
      write_n_q <= write_n;
      if (wr_gain)
        gain_setting <= data_in[`ARHP_GAIN_HI:0];
      if (wr_offset)
        offset_trim <= data_in[`ARHP_OFFSET_HI:0];
      // reserved bits are stored as written; the host keeps them zero
      if (wr_control)
        converter_control <= data_in;
    end
  end

  // ----------------------------------------------------------------
  // control fields
  // ----------------------------------------------------------------
  wire sleep_mode = converter_control[`ARHP_CTL_SLEEP];
  wire ext_bandgap = converter_control[`ARHP_CTL_EXT_BANDGAP];
  wire twos_comp = converter_control[`ARHP_CTL_TWOS_COMP];
  wire trim_bypass = converter_control[`ARHP_CTL_TRIM_BYPASS];
  wire [2:0] self_check_sel =
    converter_control[`ARHP_CTL_CHECK_HI:`ARHP_CTL_CHECK_LO];

  // ----------------------------------------------------------------
  // analog steering: source 0 signal, 1 ref-, 2 ref+, 3 common mode
  // ----------------------------------------------------------------
  logic [1:0] pos_src;
  logic [1:0] neg_src;
  always_comb
  begin
    case (arhp_pkg::arhp_check_type'(self_check_sel))
      arhp_pkg::ARHP_CHK_BOTH_NEG:
      begin
        pos_src = 2'h1;
        neg_src = 2'h1;
      end
      arhp_pkg::ARHP_CHK_CM_NEG:
      begin
        pos_src = 2'h3;
        neg_src = 2'h1;
      end
      arhp_pkg::ARHP_CHK_POS_NEG:
      begin
        pos_src = 2'h2;
        neg_src = 2'h1;
      end
      arhp_pkg::ARHP_CHK_BOTH_POS:
      begin
        pos_src = 2'h2;
        neg_src = 2'h2;
      end
      arhp_pkg::ARHP_CHK_NEG_CM:
      begin
        pos_src = 2'h1;
        neg_src = 2'h3;
      end
      arhp_pkg::ARHP_CHK_NEG_POS:
      begin
        pos_src = 2'h1;
        neg_src = 2'h2;
      end
      default:
      begin
        pos_src = 2'h0;
        neg_src = 2'h0;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      analog_ctl <= '0;
    else
      analog_ctl <= '{sleep_mode, ext_bandgap, gain_setting,
                      pos_src, neg_src};
  end

  // ----------------------------------------------------------------
  // trim and format
  // ----------------------------------------------------------------
  // trim is applied on the offset-binary code and saturates so that a
  // large correction cannot wrap a full-scale code to the other end
  wire signed [15:0] trimmed = $signed({2'b00, core_code}) +
    (trim_bypass ? 16'sh0000 : 16'(signed'(offset_trim)));
  wire [13:0] clamped = trimmed < 0 ? 14'h0000 :
    (trimmed > $signed({2'b00, `ARHP_MAX_CODE}) ? `ARHP_MAX_CODE :
    trimmed[13:0]);
  // twos complement is offset binary with the top bit flipped
  wire [13:0] formatted = twos_comp ? (clamped ^ `ARHP_MID_CODE) :
    clamped;
  assign head = '{formatted, core_range};

  // ----------------------------------------------------------------
  // latency pipeline, range flag travels with its code
  // ----------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      for (int i = 0; i < DEPTH; i++)
        pipe[i] <= '0;
    end
    else
    begin
      pipe[0] <= head;
      for (int i = 1; i < DEPTH; i++)
        pipe[i] <= pipe[i-1];
    end
  end

  // the half cycle of latency falls on the falling edge
  arhp_pkg::arhp_sample_type tail;
  always_ff @(negedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      tail <= '0;
    else
      tail <= pipe[DEPTH-1];
  end
  assign conversion_result = tail.code;
  assign range_exceeded = tail.range_exceeded;

  // ----------------------------------------------------------------
  // read mux and pin drive
  // ----------------------------------------------------------------
  wire [13:0] read_word =
    addr == `ARHP_ADDR_RESULT ? conversion_result :
    addr == `ARHP_ADDR_GAIN ? {11'h000, gain_setting} :
    addr == `ARHP_ADDR_OFFSET ? {6'h00, offset_trim} :
    converter_control;

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
      data_out <= 14'h0000;
    else
      data_out <= read_word;
  end
  assign data_oe = {14{~drive_n}};
endmodule
